// ==== rtl/host_interface_select.sv ====
// Host interface front end: mode straps, serial and parallel host port, key scan
//
// Behaviour
// - Mode straps select serial, 68-style or 80-style
// - Width strap: low 8-bit, high 4-bit bus
// - Serial mode uses width strap as ID bit
// - Accesses only while chip select low
// - Register select: low instruction, high display RAM
// - Serial: register select picks key wake method
// - Serial data captured on rising transfer clock
// - Serial data pin is bidirectional
// - 68-style: enable pin launches each cycle
// - 68-style: direction pin selects read or write
// - 80-style: write strobe low takes data
// - 80-style: read strobe low drives data
// - Data pins driven only during host reads
// - 4-bit width uses upper data pins only
// - Four key strobes rotate, serial mode only
// - Key inputs sampled with active key strobe
// - Active-low key interrupt toward host
`timescale 1ns/1ps

// -----------------------------------------------------------------
// Synchronous FIFO
// -----------------------------------------------------------------
module hif_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  assign in_ready  = (count_ff != (AW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign out_data  = mem[rd_ptr_ff];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop)  rd_ptr_ff <= rd_ptr_ff + 1'b1;
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : hif_fifo

// -----------------------------------------------------------------
// Top
// -----------------------------------------------------------------
module host_interface_select #(
  parameter int                                 KEY_SLOT_CYC  = hif_pkg::KEY_SLOT_CYC,
  parameter int                                 FIFO_DEPTH    = hif_pkg::FIFO_DEPTH,
  // Serial device code prefix, arbitrary value
  parameter logic [hif_pkg::SB_PFX_W-1:0]       DEV_ID_PREFIX = 5'h0e
) (
  // Clock and reset
  input  wire logic                     CLK,
  input  wire logic                     RESET,
  // Straps
  input  wire logic                     MODE_STRAP_HI,
  input  wire logic                     MODE_STRAP_LO,
  input  wire logic                     WIDTH_OR_IDBIT_STRAP,
  // Host control pins
  input  wire logic                     CS_N,
  input  wire logic                     REGISTER_SELECT,
  input  wire logic                     STROBE_SCL,
  // Direction / read strobe / serial data pin
  input  wire logic                     DIRSDA_IN,
  output logic                          DIRSDA_OUT,
  output logic                          DIRSDA_OE_N,
  // Data bus / key input pins
  input  wire logic [7:0]               DATA_KEY_IN,
  output logic [7:0]                    DATA_KEY_OUT,
  output logic                          DATA_KEY_OE_N,
  // Key matrix and interrupt
  output logic [3:0]                    KEY_STROBE_N,
  output logic [31:0]                   KEY_MAP,
  output logic                          IRQ_N,
  // Core side: written transfers
  output logic                          XFER_VALID,
  input  wire logic                     XFER_READY,
  output hif_pkg::xfer_t                XFER,
  output logic                          HOST_BUSY,
  // Core side: read data
  output logic                          RD_REQ,
  output logic                          RD_IS_RAM,
  input  wire logic [7:0]               RD_DATA
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  wire [hif_pkg::PIN_W-1:0] pins_raw = {MODE_STRAP_HI, MODE_STRAP_LO, WIDTH_OR_IDBIT_STRAP,
                                        CS_N, REGISTER_SELECT, STROBE_SCL, DIRSDA_IN,
                                        DATA_KEY_IN};
  logic [hif_pkg::PIN_W-1:0] sync1_ff;
  logic [hif_pkg::PIN_W-1:0] sync2_ff;
  logic                      strobe_prev_ff;
  logic                      wr_lvl_prev_ff;
  logic                      rd_lvl_prev_ff;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      sync1_ff <= '1;
      sync2_ff <= '1;
    end else begin
      sync1_ff <= pins_raw;
      sync2_ff <= sync1_ff;
    end
  end

  wire [7:0]              data_s   = sync2_ff[7:0];
  wire                    sda_s    = sync2_ff[8];
  wire                    strobe_s = sync2_ff[9];
  wire                    rs_s     = sync2_ff[10];
  wire                    cs_n_s   = sync2_ff[11];
  wire                    width_s  = sync2_ff[12];
  wire hif_pkg::host_mode_t mode   = hif_pkg::host_mode_t'(sync2_ff[14:13]);

  // ---------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------
  wire is_serial = (mode == hif_pkg::MODE_SERIAL);
  wire is_p68    = (mode == hif_pkg::MODE_P68);
  wire is_p80    = (mode == hif_pkg::MODE_P80);
  wire is_par    = is_p68 | is_p80;
  wire narrow    = is_par & width_s;
  wire selected  = ~cs_n_s;

  // ---------------------------------------------------------------
  // Parallel strobe decode
  // ---------------------------------------------------------------
  wire p68_wr = is_p68 & strobe_s & ~sda_s;
  wire p68_rd = is_p68 & strobe_s & sda_s;
  wire p80_wr = is_p80 & ~strobe_s;
  wire p80_rd = is_p80 & ~sda_s;
  wire wr_lvl = selected & (p68_wr | p80_wr);
  wire rd_lvl = selected & (p68_rd | p80_rd);
  wire wr_end = wr_lvl_prev_ff & ~wr_lvl;
  wire rd_beg = rd_lvl & ~rd_lvl_prev_ff;
  wire rd_end = rd_lvl_prev_ff & ~rd_lvl;

  // ---------------------------------------------------------------
  // Serial clock edges
  // ---------------------------------------------------------------
  wire scl_rise = is_serial & selected & strobe_s & ~strobe_prev_ff;
  wire scl_fall = is_serial & selected & ~strobe_s & strobe_prev_ff;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      strobe_prev_ff <= 1'b1;
      wr_lvl_prev_ff <= 1'b0;
      rd_lvl_prev_ff <= 1'b0;
    end else begin
      strobe_prev_ff <= strobe_s;
      wr_lvl_prev_ff <= wr_lvl;
      rd_lvl_prev_ff <= rd_lvl;
    end
  end

  // ---------------------------------------------------------------
  // Parallel write capture and nibble pairing
  // ---------------------------------------------------------------
  logic [7:0] wdat_ff;
  logic       wrs_ff;
  logic [3:0] hi_nib_ff;
  logic       nib_lo_ff;
  logic [7:0] rd_byte_ff;

  wire [7:0] par_byte = narrow ? {hi_nib_ff, wdat_ff[7:4]} : wdat_ff;
  wire       par_push = wr_end & (~narrow | nib_lo_ff);

  always_ff @(posedge CLK) begin
    if (RESET) begin
      wdat_ff <= 8'h00;
      wrs_ff  <= 1'b0;
    end else if (wr_lvl) begin
      wdat_ff <= narrow ? {data_s[7:4], 4'h0} : data_s;
      wrs_ff  <= rs_s;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      nib_lo_ff <= 1'b0;
      hi_nib_ff <= 4'h0;
    end else if (!selected || !narrow) begin
      nib_lo_ff <= 1'b0;
    end else if (wr_end) begin
      hi_nib_ff <= wdat_ff[7:4];
      nib_lo_ff <= ~nib_lo_ff;
    end else if (rd_end) begin
      nib_lo_ff <= ~nib_lo_ff;
    end
  end

  // ---------------------------------------------------------------
  // Serial receive and transmit
  // ---------------------------------------------------------------
  hif_pkg::ser_state_t ser_state_ff;
  logic [2:0]          bit_cnt_ff;
  logic [7:0]          rx_sh_ff;
  logic [7:0]          tx_sh_ff;
  logic                ser_rw_ff;
  logic                ser_rs_ff;
  logic                sda_out_ff;

  wire [7:0] rx_byte   = {rx_sh_ff[6:0], sda_s};
  wire       byte_done = scl_rise & (bit_cnt_ff == 3'h7);
  wire       id_match  =
    (rx_byte[hif_pkg::SB_PFX_LSB +: hif_pkg::SB_PFX_W] == DEV_ID_PREFIX) &
    (rx_byte[hif_pkg::SB_ID_BIT] == width_s);
  wire       start_ok  = byte_done & (ser_state_ff == hif_pkg::SER_START) & id_match;
  wire       ser_rd    = start_ok ? rx_byte[hif_pkg::SB_RW_BIT] : ser_rw_ff;
  wire       ser_in_data = (ser_state_ff == hif_pkg::SER_DATA);
  wire       ser_load  = (start_ok & rx_byte[hif_pkg::SB_RW_BIT]) |
                         (byte_done & ser_in_data & ser_rw_ff);
  wire       ser_push  = byte_done & ser_in_data & ~ser_rw_ff;

  always_ff @(posedge CLK) begin
    if (RESET || !is_serial || !selected) begin
      ser_state_ff <= hif_pkg::SER_START;
      bit_cnt_ff   <= 3'h0;
      ser_rw_ff    <= 1'b0;
      ser_rs_ff    <= 1'b0;
    end else if (scl_rise) begin
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
      if (bit_cnt_ff == 3'h7) begin
        case (ser_state_ff)
          hif_pkg::SER_START: begin
            ser_state_ff <= id_match ? hif_pkg::SER_DATA : hif_pkg::SER_IGNORE;
            ser_rw_ff    <= ser_rd;
            ser_rs_ff    <= rx_byte[hif_pkg::SB_RS_BIT];
          end
          hif_pkg::SER_DATA:   ser_state_ff <= hif_pkg::SER_DATA;
          hif_pkg::SER_IGNORE: ser_state_ff <= hif_pkg::SER_IGNORE;
          default:             ser_state_ff <= hif_pkg::SER_START;
        endcase
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      rx_sh_ff <= 8'h00;
    end else if (scl_rise) begin
      rx_sh_ff <= rx_byte;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      tx_sh_ff   <= 8'h00;
      sda_out_ff <= 1'b1;
    end else if (ser_load) begin
      tx_sh_ff <= RD_DATA;
    end else if (scl_fall && ser_in_data && ser_rw_ff) begin
      sda_out_ff <= tx_sh_ff[7];
      tx_sh_ff   <= {tx_sh_ff[6:0], 1'b0};
    end
  end

  // ---------------------------------------------------------------
  // Read request toward the core and read data
  // ---------------------------------------------------------------
  wire par_rd_req = rd_beg & (~narrow | ~nib_lo_ff);

  always_ff @(posedge CLK) begin
    if (RESET) begin
      rd_byte_ff <= 8'h00;
    end else if (par_rd_req) begin
      rd_byte_ff <= RD_DATA;
    end
  end

  assign RD_REQ    = par_rd_req | ser_load;
  assign RD_IS_RAM = ser_load ? (start_ok ? rx_byte[hif_pkg::SB_RS_BIT] : ser_rs_ff) : rs_s;

  wire [7:0] rd_src = par_rd_req ? RD_DATA : rd_byte_ff;
  wire [7:0] rd_pin = ~narrow ? rd_src :
                      nib_lo_ff ? {rd_src[3:0], 4'h0} : {rd_src[7:4], 4'h0};

  logic [7:0] dout_ff;
  logic       doe_n_ff;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      dout_ff  <= 8'h00;
      doe_n_ff <= 1'b1;
    end else begin
      dout_ff  <= rd_pin;
      doe_n_ff <= ~(is_par & rd_lvl);
    end
  end

  assign DATA_KEY_OUT  = dout_ff;
  assign DATA_KEY_OE_N = doe_n_ff;
  assign DIRSDA_OUT    = sda_out_ff;
  assign DIRSDA_OE_N   = ~(ser_in_data & ser_rw_ff & is_serial & selected);

  // ---------------------------------------------------------------
  // Transfer FIFO toward the core
  // ---------------------------------------------------------------
  hif_pkg::xfer_t push_word;
  logic           fifo_in_ready;

  assign push_word.is_ram = ser_push ? ser_rs_ff : wrs_ff;
  assign push_word.data   = ser_push ? rx_byte : par_byte;

  hif_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .reset     (RESET),
    .in_valid  (par_push | ser_push),
    .in_ready  (fifo_in_ready),
    .in_data   (push_word),
    .out_valid (XFER_VALID),
    .out_ready (XFER_READY),
    .out_data  (XFER)
  );

  assign HOST_BUSY = ~fifo_in_ready;

  // ---------------------------------------------------------------
  // Key scan
  // ---------------------------------------------------------------
  logic [$clog2(KEY_SLOT_CYC)-1:0] slot_cnt_ff;
  logic [1:0]                      key_idx_ff;
  logic [31:0]                     key_map_ff;
  logic                            irq_n_ff;

  wire slot_end = (slot_cnt_ff == ($clog2(KEY_SLOT_CYC))'(KEY_SLOT_CYC - 1));

  always_ff @(posedge CLK) begin
    if (RESET || !is_serial) begin
      slot_cnt_ff <= '0;
      key_idx_ff  <= 2'h0;
    end else if (slot_end) begin
      slot_cnt_ff <= '0;
      key_idx_ff  <= key_idx_ff + 2'h1;
    end else begin
      slot_cnt_ff <= slot_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET || !is_serial) begin
      key_map_ff <= 32'h0000_0000;
    end else if (slot_end) begin
      key_map_ff[key_idx_ff*8 +: 8] <= ~data_s;
    end
  end

  wire key_event = rs_s ? (key_map_ff != 32'h0000_0000)
                        : (key_map_ff[7:0] != 8'h00);

  always_ff @(posedge CLK) begin
    if (RESET) begin
      irq_n_ff <= 1'b1;
    end else begin
      irq_n_ff <= ~(is_serial & key_event);
    end
  end

  assign KEY_STROBE_N = is_serial ? ~(4'h1 << key_idx_ff) : 4'hf;
  assign KEY_MAP      = key_map_ff;
  assign IRQ_N        = irq_n_ff;

endmodule : host_interface_select

// ==== rtl/hif_pkg.sv ====
// Shared types and constants of the host interface front end
package hif_pkg;

  // ---------------------------------------------------------------
  // Host modes, from the two mode straps {hi, lo}
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SERIAL = 2'b00,
    MODE_P68    = 2'b01,
    MODE_BAD    = 2'b10,
    MODE_P80    = 2'b11
  } host_mode_t;

  // ---------------------------------------------------------------
  // Serial link states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SER_START  = 2'b00,
    SER_DATA   = 2'b01,
    SER_IGNORE = 2'b10
  } ser_state_t;

  // ---------------------------------------------------------------
  // One transfer toward the core: path and byte
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       is_ram;
    logic [7:0] data;
  } xfer_t;

  // ---------------------------------------------------------------
  // Widths, depths, field positions
  // ---------------------------------------------------------------
  localparam int DATA_W      = 8;
  localparam int FIFO_DEPTH  = 16;
  localparam int KEY_LINES   = 4;
  localparam int KEY_INS     = 8;
  localparam int PIN_W       = 15;
  localparam int SB_RW_BIT   = 0;
  localparam int SB_RS_BIT   = 1;
  localparam int SB_ID_BIT   = 2;
  localparam int SB_PFX_LSB  = 3;
  localparam int SB_PFX_W    = 5;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ       = 20_000_000;
  localparam int KEY_SLOT_US  = 1000;
  localparam int KEY_SLOT_CYC = (CLK_HZ / 1_000_000) * KEY_SLOT_US;

endpackage : hif_pkg

// ==== sim/host_interface_select_properties.sv ====
// Port checker of the host interface front end
`timescale 1ns/1ps
module hif_checker #(
  parameter int KEY_SLOT_CYC = 20
) (
  // Clock, reset, straps
  input wire logic           CLK,
  input wire logic           RESET,
  input wire logic           MODE_STRAP_HI,
  input wire logic           MODE_STRAP_LO,
  input wire logic           WIDTH_OR_IDBIT_STRAP,
  // Host pins
  input wire logic           CS_N,
  input wire logic           DIRSDA_OE_N,
  input wire logic [7:0]     DATA_KEY_OUT,
  input wire logic           DATA_KEY_OE_N,
  input wire logic [3:0]     KEY_STROBE_N,
  input wire logic           IRQ_N,
  // Core side
  input wire logic           XFER_VALID,
  input wire logic           XFER_READY,
  input wire hif_pkg::xfer_t XFER,
  input wire logic           RD_REQ,
  input wire logic [7:0]     RD_DATA
);
  logic [3:0]  ks_q;
  logic [15:0] cnt;
  logic [7:0]  rd_q;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  // Slot length counter
  always_ff @(posedge CLK) begin
    ks_q <= KEY_STROBE_N;
    rd_q <= RD_DATA;
    cnt  <= (RESET || KEY_STROBE_N != ks_q) ? 16'h0 : cnt + 16'h1;
  end

  sequence s_ser;
    (!MODE_STRAP_HI && !MODE_STRAP_LO) [*6];
  endsequence
  sequence s_par;
    MODE_STRAP_LO [*5];
  endsequence

  AST_SCAN_PAR: assert property (s_par |-> KEY_STROBE_N == 4'hf)
    else $error("key strobes active in parallel mode");
  AST_SCAN_ONE: assert property (s_ser |-> $onehot(~KEY_STROBE_N))
    else $error("key strobes not one at a time");
  AST_SCAN_SLOT: assert property (KEY_STROBE_N != ks_q && ks_q != 4'hf && KEY_STROBE_N != 4'hf
    |-> cnt == KEY_SLOT_CYC - 1)
    else $error("key strobe slot length wrong");
  AST_DATA_SER: assert property (s_ser |-> DATA_KEY_OE_N)
    else $error("data pins driven in serial mode");
  AST_SDA_PAR: assert property (s_par |-> DIRSDA_OE_N)
    else $error("serial data pin driven in parallel mode");
  AST_IRQ_PAR: assert property (s_par |-> IRQ_N)
    else $error("key interrupt in parallel mode");
  AST_RD_CS: assert property (RD_REQ |-> !$past(CS_N, 2))
    else $error("read request without chip select");
  AST_RD_OUT: assert property (RD_REQ && MODE_STRAP_LO |=> !DATA_KEY_OE_N
    && DATA_KEY_OUT == (WIDTH_OR_IDBIT_STRAP ? {rd_q[7:4], 4'h0} : rd_q))
    else $error("read data not on bus");
  AST_XFER_HOLD: assert property (XFER_VALID && !XFER_READY |=> XFER_VALID && $stable(XFER))
    else $error("transfer dropped before ready");
endmodule : hif_checker

bind host_interface_select hif_checker #(.KEY_SLOT_CYC(KEY_SLOT_CYC)) chk_u (
  .CLK(CLK), .RESET(RESET), .MODE_STRAP_HI(MODE_STRAP_HI), .MODE_STRAP_LO(MODE_STRAP_LO),
  .WIDTH_OR_IDBIT_STRAP(WIDTH_OR_IDBIT_STRAP), .CS_N(CS_N), .DIRSDA_OE_N(DIRSDA_OE_N),
  .DATA_KEY_OUT(DATA_KEY_OUT), .DATA_KEY_OE_N(DATA_KEY_OE_N), .KEY_STROBE_N(KEY_STROBE_N),
  .IRQ_N(IRQ_N), .XFER_VALID(XFER_VALID), .XFER_READY(XFER_READY), .XFER(XFER),
  .RD_REQ(RD_REQ), .RD_DATA(RD_DATA));

// ==== sim/hif_host_model.sv ====
// Host processor and key matrix model on the host pins
`timescale 1ns/1ps
module hif_host_model (
  // Clock and mode
  input  wire logic       clk,
  input  wire logic       p80,
  input  wire logic       ser,
  // Host driven pins
  output logic            cs_n,
  output logic            rs,
  output logic            scl,
  output logic            sda,
  output logic [7:0]      dat,
  // Device driven pins
  input  wire logic       sda_out,
  input  wire logic       sda_oe_n,
  input  wire logic [7:0] dat_out,
  input  wire logic       dat_oe_n,
  input  wire logic [3:0] kst_n
);
  logic        sda_h = 1'b1;
  logic        sda_drv = 1'b1;
  logic        dat_drv = 1'b0;
  logic [7:0]  dat_h = 8'h00;
  logic [31:0] keys = 32'h0;
  wire  [7:0]  kin;

  // Pressed key pulls its input low while its strobe is low
  assign kin = ~(({8{~kst_n[0]}} & keys[7:0]) | ({8{~kst_n[1]}} & keys[15:8])
    | ({8{~kst_n[2]}} & keys[23:16]) | ({8{~kst_n[3]}} & keys[31:24]));
  // Released lines show the inverse of the last value
  assign sda = !sda_oe_n ? sda_out : (sda_drv ? sda_h : ~sda_h);
  assign dat = ser ? kin : (!dat_oe_n ? dat_out : (dat_drv ? dat_h : ~dat_h));
  initial cs_n = 1'b1;
  initial rs = 1'b0;
  initial scl = 1'b0;

  task sel(input logic c, input logic r);
    @(negedge clk);
    cs_n  = c;
    rs    = r;
    scl   = p80;
    sda_h = 1'b1;
    repeat (4) @(negedge clk);
  endtask : sel

  task par(input logic rd, input logic [7:0] d, output logic [7:0] q);
    dat_h   = d;
    dat_drv = !rd;
    sda_h   = p80 ? !rd : rd;
    repeat (4) @(negedge clk);
    scl = p80 ? rd : 1'b1;
    repeat (4) @(negedge clk);
    q       = dat;
    scl     = p80;
    sda_h   = 1'b1;
    dat_drv = 1'b0;
    repeat (4) @(negedge clk);
  endtask : par

  task ser_byte(input logic [7:0] tx, input logic drv, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sda_h   = tx[i];
      sda_drv = drv;
      repeat (4) @(negedge clk);
      scl   = 1'b1;
      rx[i] = sda;
      repeat (4) @(negedge clk);
      scl = 1'b0;
    end
    sda_drv = 1'b1;
  endtask : ser_byte
endmodule : hif_host_model

// ==== sim/tb_host_interface_select.sv ====
// Self-checking testbench of the host interface front end
`timescale 1ns/1ps
module tb_host_interface_select;
  localparam int         SLOT = 20;
  localparam logic [4:0] ID   = 5'h0e; // Arbitrary device code prefix
  logic           clk = 1'b0;
  logic           reset = 1'b1;
  logic           s_hi = 1'b0;
  logic           s_lo = 1'b0;
  logic           s_w = 1'b0;
  logic           xfer_ready = 1'b0;
  logic [7:0]     rd_data = 8'h00;
  logic [7:0]     q;
  int             n_mismatch = 0;
  int             n_tests = 0;
  wire            cs_n, rs, scl, sda, sda_out, sda_oe_n, dat_oe_n, irq_n, xfer_valid, busy;
  wire [7:0]      dat, dat_out;
  wire [3:0]      kst_n;
  wire [31:0]     key_map;
  wire            rd_req, rd_is_ram;
  logic           rd_ram_q = 1'b0;
  hif_pkg::xfer_t xfer;

  always #25 clk = ~clk;

  // Path of the last read request toward the core
  always @(posedge clk) begin
    if (rd_req === 1'b1) rd_ram_q <= rd_is_ram;
  end

  host_interface_select #(.KEY_SLOT_CYC(SLOT), .FIFO_DEPTH(16), .DEV_ID_PREFIX(ID)) dut_u (
    .CLK(clk), .RESET(reset), .MODE_STRAP_HI(s_hi), .MODE_STRAP_LO(s_lo),
    .WIDTH_OR_IDBIT_STRAP(s_w), .CS_N(cs_n), .REGISTER_SELECT(rs), .STROBE_SCL(scl),
    .DIRSDA_IN(sda), .DIRSDA_OUT(sda_out), .DIRSDA_OE_N(sda_oe_n), .DATA_KEY_IN(dat),
    .DATA_KEY_OUT(dat_out), .DATA_KEY_OE_N(dat_oe_n), .KEY_STROBE_N(kst_n),
    .KEY_MAP(key_map), .IRQ_N(irq_n), .XFER_VALID(xfer_valid), .XFER_READY(xfer_ready),
    .XFER(xfer), .HOST_BUSY(busy), .RD_REQ(rd_req), .RD_IS_RAM(rd_is_ram), .RD_DATA(rd_data));

  hif_host_model host_u (
    .clk(clk), .p80(s_hi), .ser(!s_lo), .cs_n(cs_n), .rs(rs), .scl(scl), .sda(sda),
    .dat(dat), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .dat_out(dat_out),
    .dat_oe_n(dat_oe_n), .kst_n(kst_n));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    if (got !== exp)
      n_mismatch++;
  endtask : chk

  task setmode(input logic hi, input logic lo, input logic w);
    @(negedge clk);
    s_hi  = hi;
    s_lo  = lo;
    s_w   = w;
    reset = 1'b1;
    repeat (4) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
  endtask : setmode

  task take(input logic [8:0] exp);
    int n;
    n = 0;
    while (xfer_valid !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk({23'h0, xfer}, {23'h0, exp});
    xfer_ready = 1'b1;
    @(negedge clk);
    xfer_ready = 1'b0;
  endtask : take

  task t_fifo;
    setmode(1'b1, 1'b1, 1'b0);
    host_u.sel(1'b1, 1'b1);
    host_u.par(1'b0, 8'hee, q);
    host_u.sel(1'b0, 1'b1);
    for (int i = 0; i < 17; i++) host_u.par(1'b0, 8'h10 + 8'(i), q);
    chk({31'h0, busy}, 32'h1);
    host_u.sel(1'b1, 1'b1);
    for (int i = 0; i < 16; i++) take({1'b1, 8'h10 + 8'(i)});
    chk({31'h0, xfer_valid}, 32'h0);
  endtask : t_fifo

  task t_nib68;
    setmode(1'b0, 1'b1, 1'b1);
    host_u.sel(1'b0, 1'b0);
    host_u.par(1'b0, 8'h3a, q);
    host_u.par(1'b0, 8'hc5, q);
    take({1'b0, 8'h3c});
    rd_data = 8'h5a;
    host_u.par(1'b1, 8'h00, q);
    chk({24'h0, q}, 32'h50);
    chk({31'h0, rd_ram_q}, 32'h0);
    host_u.par(1'b1, 8'h00, q);
    chk({24'h0, q}, 32'ha0);
    host_u.sel(1'b1, 1'b0);
  endtask : t_nib68

  task t_rd80;
    setmode(1'b1, 1'b1, 1'b0);
    rd_data = 8'hc3;
    host_u.sel(1'b1, 1'b1);
    host_u.par(1'b1, 8'h00, q);
    chk({24'h0, q}, 32'hff);
    host_u.sel(1'b0, 1'b1);
    host_u.par(1'b1, 8'h00, q);
    chk({24'h0, q}, 32'hc3);
    chk({31'h0, rd_ram_q}, 32'h1);
    host_u.sel(1'b1, 1'b1);
    chk({31'h0, dat_oe_n}, 32'h1);
  endtask : t_rd80

  task t_serial;
    setmode(1'b0, 1'b0, 1'b1);
    host_u.sel(1'b0, 1'b1);
    host_u.ser_byte({ID, 3'b110}, 1'b1, q);
    host_u.ser_byte(8'h96, 1'b1, q);
    host_u.sel(1'b1, 1'b1);
    take({1'b1, 8'h96});
    host_u.sel(1'b0, 1'b1);
    host_u.ser_byte({ID, 3'b010}, 1'b1, q);
    host_u.ser_byte(8'h77, 1'b1, q);
    host_u.sel(1'b1, 1'b1);
    rd_data = 8'hb4;
    host_u.sel(1'b0, 1'b1);
    host_u.ser_byte({ID, 3'b111}, 1'b1, q);
    host_u.ser_byte(8'h00, 1'b0, q);
    chk({24'h0, q}, 32'hb4);
    host_u.sel(1'b1, 1'b1);
    chk({31'h0, xfer_valid}, 32'h0);
  endtask : t_serial

  task t_keys;
    host_u.sel(1'b1, 1'b0);
    host_u.keys = 32'h0008_0000;
    repeat (6 * SLOT) @(negedge clk);
    chk(key_map, 32'h0008_0000);
    chk({31'h0, irq_n}, 32'h1);
    host_u.keys = 32'h0000_0020;
    repeat (6 * SLOT) @(negedge clk);
    chk({31'h0, irq_n}, 32'h0);
    host_u.sel(1'b1, 1'b1);
    host_u.keys = 32'h0008_0000;
    repeat (6 * SLOT) @(negedge clk);
    chk({31'h0, irq_n}, 32'h0);
    host_u.keys = 32'h0;
    repeat (6 * SLOT) @(negedge clk);
    chk({31'h0, irq_n}, 32'h1);
  endtask : t_keys

  task close_out;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  initial begin
    repeat (4) @(negedge clk);
    reset = 1'b0;
    t_fifo;
    t_nib68;
    t_rd80;
    t_serial;
    t_keys;
    close_out;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    close_out;
  end
endmodule : tb_host_interface_select
